/* File: hdl/ref_tempsense_reg_ctrl.sv */
// apb register bank for reference, temperature sensor and regulator
`timescale 1ns/1ps
`include "ref_tempsense_cfg.svh"

// What this block does
// R1 - offset low bits 7:6 return offset bits 1:0
// R2 - offset equals converter result at 0 C
// R3 - offset LSB weight equals converter LSB
// R4 - offset low bits 5:0 read zero
// R5 - reference control bits 7:5 read zero
// R6 - reference control bits 1:0 read zero
// R7 - override bit forces regulator reference
// R8 - select bit: 0 pin, 1 supply
// R9 - sensor enable powers temperature sensor
// R10 - stop config clear keeps regulator on
// R11 - stop config set shuts regulator in stop
// R12 - software bypasses only with external regulator
// R13 - software sets reference pin analog, skipped
// R14 - disabled sensor output is high impedance
// R15 - writes take effect at completing edge; outputs update one edge later
module ref_tempsense_reg_ctrl
  import ref_tempsense_pkg::*;
#(
  parameter logic [9:0] TEMP_OFFSET_VALUE = `TEMP_OFFSET_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_request,
  input wire logic wake_event,
  input wire logic rst_pin_event,
  output ref_source_e ref_source,
  output logic sensor_power_on,
  output logic sensor_output_en_n,
  output logic regulator_on,
  output logic regulator_bypass,
  output logic mem_power_ctrl_en,
  output logic reset_sources_live,
  output logic in_stop
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic is_addr(input logic [11:0] a,
                                   input logic [7:0] idx);
    // byte offset bits 1:0 play no part in the decode
    is_addr = (a[11:2] == {2'b00, idx});
  endfunction

  logic access;
  logic hit_temp_offset_low;
  logic hit_toffh;
  logic hit_ref;
  logic hit_reg;
  logic mapped;

  assign access = psel & penable;
  assign hit_temp_offset_low = is_addr(paddr, `TEMP_OFFSET_LOW_IDX);
  assign hit_toffh = is_addr(paddr, `TEMP_OFFSET_HIGH_IDX);
  assign hit_ref = is_addr(paddr, `REFERENCE_CONTROL_IDX);
  assign hit_reg = is_addr(paddr, `REGULATOR_CONTROL_IDX);
  assign mapped = hit_temp_offset_low | hit_toffh | hit_ref | hit_reg;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] ref_q;
  logic [7:0] ref_d;
  logic [7:0] reg_q;
  logic [7:0] reg_d;
  logic [1:0] temp_offset_value_low_q;
  logic [1:0] temp_offset_value_low_d;
  logic [7:0] temp_offset_value_high_q;
  logic [7:0] temp_offset_value_high_d;
  logic wr_ok;

  // only byte lane 0 carries data; other lanes are ignored
  assign wr_ok = access & pwrite & pstrb[0];

  always_comb begin
    ref_d = ref_q;
    reg_d = reg_q;
    temp_offset_value_low_d = temp_offset_value_low_q;
    temp_offset_value_high_d = temp_offset_value_high_q;
    if (wr_ok && hit_ref) begin
      // unused bits never store anything [R5] [R6]
      ref_d = pwdata[7:0] & `REFERENCE_CONTROL_WMASK; // [R15]
    end
    if (wr_ok && hit_reg) begin
      // reserved regulator bits are dropped and read back zero
      reg_d = pwdata[7:0] & `REGULATOR_CONTROL_WMASK; // [R15]
    end
    if (wr_ok && hit_temp_offset_low) begin
      // only the top two bits hold offset data [R4]
      temp_offset_value_low_d = pwdata[`OFFSET_LOW_MSB:`OFFSET_LOW_LSB]; // [R1]
    end
    if (wr_ok && hit_toffh) begin
      temp_offset_value_high_d = pwdata[7:0];
    end
  end

  // the offset resets to the factory value, the 0 C converter code
  // taken with the regulator as reference, same lsb weight [R2] [R3]
  // the offset stays writable so a board can keep its own calibration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= `REFERENCE_CONTROL_RESET;
      reg_q <= `REGULATOR_CONTROL_RESET;
      temp_offset_value_low_q <= TEMP_OFFSET_VALUE[1:0];
      temp_offset_value_high_q <= TEMP_OFFSET_VALUE[9:2];
    end else begin
      ref_q <= ref_d;
      reg_q <= reg_d;
      temp_offset_value_low_q <= temp_offset_value_low_d;
      temp_offset_value_high_q <= temp_offset_value_high_d;
    end
  end

  // ----------------------------------------------------------------
  // read path and answer
  // ----------------------------------------------------------------
  logic [31:0] rdata_d;
  logic [31:0] prdata_d;
  logic pslverr_d;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_temp_offset_low) begin
      rdata_d[7:0] = {temp_offset_value_low_q, 6'h00}; // [R1] [R4]
    end else if (hit_toffh) begin
      rdata_d[7:0] = temp_offset_value_high_q;
    end else if (hit_ref) begin
      rdata_d[7:0] = ref_q & `REFERENCE_CONTROL_WMASK; // [R5] [R6]
    end else if (hit_reg) begin
      rdata_d[7:0] = reg_q;
    end
    prdata_d = prdata;
    pslverr_d = 1'b0;
    // captured in the setup cycle so the answer already stands when
    // pready is sampled at the access edge; reads have no side effects,
    // so taking them one cycle early is harmless
    if (psel && !penable) begin
      prdata_d = pwrite ? 32'h0000_0000 : rdata_d;
      // a stray address still completes, flagged rather than stalled
      pslverr_d = ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= prdata_d;
      pslverr <= pslverr_d;
    end
  end

  // zero wait states: pready goes high at the first edge after reset and stays high
  // low in reset so nothing completes against a block still waking up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // reference and sensor outputs
  // ----------------------------------------------------------------
  ref_ctrl_s ref_fields;
  ref_source_e source_d;

  assign ref_fields.regulator_ref_override = ref_q[`REF_OVERRIDE_BIT];
  assign ref_fields.reference_select = ref_q[`REF_SELECT_BIT];
  assign ref_fields.sensor_enable = ref_q[`REF_SENSOR_EN_BIT];

  ref_source_mux u_mux (
    .ctrl(ref_fields),
    .source(source_d)
  );

  logic sensor_power_on_d;
  logic sensor_output_en_n_d;

  always_comb begin
    sensor_power_on_d = ref_fields.sensor_enable; // [R9]
    // an unpowered sensor must not drive the converter input [R14]
    sensor_output_en_n_d = ~ref_fields.sensor_enable;
  end

  // outputs track the register one edge after it updates [R15]
  // registering keeps decode glitches off the analog switches, at the
  // cost of one cycle of lag after a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_source <= REF_EXTERNAL_PIN;
      sensor_power_on <= 1'b0;
      sensor_output_en_n <= 1'b1;
    end else begin
      ref_source <= source_d; // [R7] [R8]
      sensor_power_on <= sensor_power_on_d; // [R9]
      sensor_output_en_n <= sensor_output_en_n_d; // [R14]
    end
  end

  // ----------------------------------------------------------------
  // regulator power state
  // ----------------------------------------------------------------
  // software alone is trusted to set bypass with a 1.8 v external
  // supply; the block cannot see the supply and does not police it
  reg_ctrl_s reg_fields;
  power_state_e pwr_q;
  power_state_e pwr_d;

  assign reg_fields.stop_config = reg_q[`REG_STOP_CFG_BIT];
  assign reg_fields.bypass = reg_q[`REG_BYPASS_BIT];
  assign reg_fields.mem_power = reg_q[`REG_MEM_POWER_BIT];

  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      PWR_RUN: begin
        if (stop_request) begin
          pwr_d = reg_fields.stop_config ? PWR_STOP_REG_OFF // [R11]
                                         : PWR_STOP_REG_ON; // [R10]
        end
      end
      PWR_STOP_REG_ON: begin
        // any enabled reset or wake source still ends stop [R10]
        if (wake_event || rst_pin_event) begin
          pwr_d = PWR_RUN;
        end
      end
      PWR_STOP_REG_OFF: begin
        // only the reset pin gets out; power cycle is presetn [R11]
        if (rst_pin_event) begin
          pwr_d = PWR_RUN;
        end
      end
      default: begin
        pwr_d = PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q <= PWR_RUN;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  // stop with the regulator down leaves only the pin path alive
  function automatic logic regulator_down(input power_state_e s);
    regulator_down = (s == PWR_STOP_REG_OFF);
  endfunction

  logic regulator_on_d;
  logic regulator_bypass_d;
  logic mem_power_ctrl_en_d;
  logic reset_sources_live_d;
  logic in_stop_d;

  // state outputs are built from the next state so they move on the same edge as it; bypass and mem power follow the register
  always_comb begin
    // bypass or a shut-down stop both turn the regulator off [R10] [R11]
    regulator_on_d = ~reg_fields.bypass & ~regulator_down(pwr_d);
    regulator_bypass_d = reg_fields.bypass; // [R12]
    mem_power_ctrl_en_d = reg_fields.mem_power;
    reset_sources_live_d = ~regulator_down(pwr_d); // [R11]
    // both stop flavours halt the core alike
    in_stop_d = (pwr_d != PWR_RUN);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_on <= 1'b1;
      regulator_bypass <= 1'b0;
      mem_power_ctrl_en <= 1'b0;
      reset_sources_live <= 1'b1;
      in_stop <= 1'b0;
    end else begin
      regulator_on <= regulator_on_d;
      regulator_bypass <= regulator_bypass_d;
      mem_power_ctrl_en <= mem_power_ctrl_en_d;
      reset_sources_live <= reset_sources_live_d;
      in_stop <= in_stop_d;
    end
  end

endmodule // ref_tempsense_reg_ctrl

/* File: hdl/ref_tempsense_cfg.svh */
// constants for the reference, sensor and regulator register bank
`ifndef REF_TEMPSENSE_CFG_SVH
`define REF_TEMPSENSE_CFG_SVH

// ----------------------------------------------------------------
// register word indices (apb byte address bits 11:2)
// ----------------------------------------------------------------
`define TEMP_OFFSET_LOW_IDX 8'ha2
`define REFERENCE_CONTROL_IDX 8'hd1
`define REGULATOR_CONTROL_IDX 8'hc7
`define TEMP_OFFSET_HIGH_IDX 8'ha3
`define ADDR_OF(idx) ({idx, 2'b00})

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OFFSET_LOW_MSB 7
`define OFFSET_LOW_LSB 6
`define REF_OVERRIDE_BIT 4
`define REF_SELECT_BIT 3
`define REF_SENSOR_EN_BIT 2
`define REG_STOP_CFG_BIT 7
`define REG_BYPASS_BIT 6
`define REG_MEM_POWER_BIT 0

// ----------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------
`define REFERENCE_CONTROL_RESET 8'h00
`define REFERENCE_CONTROL_WMASK 8'h1c
`define REGULATOR_CONTROL_RESET 8'h00
`define REGULATOR_CONTROL_WMASK 8'hc1
`define TEMP_OFFSET_DEFAULT 10'h000

`endif

/* File: hdl/ref_tempsense_pkg.sv */
// types for the reference, sensor and regulator register bank
package ref_tempsense_pkg;

  typedef enum logic [1:0] {
    REF_EXTERNAL_PIN,
    REF_SUPPLY,
    REF_REGULATOR
  } ref_source_e;

  typedef struct packed {
    logic regulator_ref_override;
    logic reference_select;
    logic sensor_enable;
  } ref_ctrl_s;

  typedef struct packed {
    logic stop_config;
    logic bypass;
    logic mem_power;
  } reg_ctrl_s;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_STOP_REG_ON,
    PWR_STOP_REG_OFF
  } power_state_e;

endpackage

/* File: hdl/ref_source_mux.sv */
// reference source selection from the control bits
`timescale 1ns/1ps

module ref_source_mux
  import ref_tempsense_pkg::*;
(
  input wire ref_ctrl_s ctrl,
  output ref_source_e source
);

  always_comb begin
    if (ctrl.regulator_ref_override) begin
      source = REF_REGULATOR; // [R7]
    end else if (ctrl.reference_select) begin
      source = REF_SUPPLY; // [R8]
    end else begin
      source = REF_EXTERNAL_PIN; // [R8]
    end
  end

endmodule // ref_source_mux

/* File: verification/ref_tempsense_assertions.sv */
// assertions for the reference, sensor and regulator register bank
`timescale 1ns/1ps

module ref_tempsense_assertions
  import ref_tempsense_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire ref_source_e ref_source,
  input wire logic sensor_power_on,
  input wire logic sensor_output_en_n,
  input wire logic regulator_on,
  input wire logic regulator_bypass,
  input wire logic reset_sources_live,
  input wire logic in_stop
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr_ref;
  assign acc = psel && penable && pready;
  assign wr_ref = acc && pwrite && pstrb[0] && paddr == 12'h344;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // outputs are looked at two edges on so both register stages settle
  property p_ovr;
    wr_ref && pwdata[4] |-> ##2 ref_source == REF_REGULATOR;
  endproperty
  a_ovr: assert property (p_ovr) else $error("override ignored");
  property p_ext;
    wr_ref && pwdata[4:3] == 2'b00 |-> ##2 ref_source == REF_EXTERNAL_PIN;
  endproperty
  a_ext: assert property (p_ext) else $error("pin source wrong");
  property p_sup;
    wr_ref && pwdata[4:3] == 2'b01 |-> ##2 ref_source == REF_SUPPLY;
  endproperty
  a_sup: assert property (p_sup) else $error("supply source wrong");
  property p_sen;
    wr_ref |-> ##2 sensor_power_on == $past(pwdata[2], 2);
  endproperty
  a_sen: assert property (p_sen) else $error("sensor power wrong");
  property p_hiz;
    sensor_output_en_n != sensor_power_on;
  endproperty
  a_hiz: assert property (p_hiz) else $error("sensor output drive");
  property p_stop_on;
    in_stop && reset_sources_live |-> regulator_on || regulator_bypass;
  endproperty
  a_stop_on: assert property (p_stop_on) else $error("regulator off");
  property p_stop_off;
    !reset_sources_live |-> !regulator_on && in_stop;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("bad shutdown");
  property p_rd_low;
    acc && !pwrite && paddr == 12'h288 |-> (prdata & 32'hffffff3f) == 0;
  endproperty
  a_rd_low: assert property (p_rd_low) else $error("offset low bits");
  property p_rd_ref;
    acc && !pwrite && paddr == 12'h344 |-> (prdata & 32'hffffffe3) == 0;
  endproperty
  a_rd_ref: assert property (p_rd_ref) else $error("unused bits");
endmodule // ref_tempsense_assertions

bind ref_tempsense_reg_ctrl ref_tempsense_assertions
  i_ref_tempsense_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .ref_source(ref_source),
  .sensor_power_on(sensor_power_on), .sensor_output_en_n(sensor_output_en_n),
  .regulator_on(regulator_on), .regulator_bypass(regulator_bypass),
  .reset_sources_live(reset_sources_live), .in_stop(in_stop)
);

/* File: verification/tb.sv */
// self-checking testbench for the reference and sensor register bank
`timescale 1ns/1ps

module tb;
  import ref_tempsense_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic stop_request, wake_event, rst_pin_event, sensor_power_on;
  logic sensor_output_en_n, regulator_on, regulator_bypass;
  logic mem_power_ctrl_en, reset_sources_live, in_stop;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  ref_source_e ref_source, exp_src;
  int mismatches, n_checks;

  ref_tempsense_reg_ctrl #(
    .TEMP_OFFSET_VALUE(10'h2c7)
  ) i_ref_tempsense_reg_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_request(stop_request), .wake_event(wake_event),
    .rst_pin_event(rst_pin_event), .ref_source(ref_source),
    .sensor_power_on(sensor_power_on),
    .sensor_output_en_n(sensor_output_en_n), .regulator_on(regulator_on),
    .regulator_bypass(regulator_bypass), .mem_power_ctrl_en(mem_power_ctrl_en),
    .reset_sources_live(reset_sources_live), .in_stop(in_stop)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic summarize();
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one apb transfer; read data and error are taken at the edge at which
  // pready is sampled high, then the bus idles for one cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'hffffff, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) begin
      mismatches++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pulse_wait(input int k, input logic v);
    int n;
    n = 0;
    if (k == 0) stop_request <= 1'b1;
    if (k == 1) wake_event <= 1'b1;
    if (k == 2) rst_pin_event <= 1'b1;
    @(posedge pclk);
    {stop_request, wake_event, rst_pin_event} <= 3'b000;
    while (in_stop !== v && n < 20) begin @(posedge pclk); n++; end
    if (n == 20) begin mismatches++; summarize(); end
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    summarize();
  end

  initial begin
    {presetn, psel, penable, pwrite, stop_request, wake_event} = 0;
    rst_pin_event = 0; paddr = 0; pwdata = 0; pstrb = 4'h1;
    mismatches = 0; n_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h344, 8'h00); chk("ref_rst", rd, 32'h0);
    apb(1'b0, 12'h28c, 8'h00); chk("off_hi", rd, 32'hb1);
    apb(1'b0, 12'h288, 8'h00); chk("off_lo", rd, 32'hc0);
    apb(1'b1, 12'h288, 8'h3f); apb(1'b0, 12'h288, 8'h00);
    chk("off_wr", rd, 32'h0);
    for (int v = 0; v < 8; v++) begin
      // pin setup for an external reference is software's job
      apb(1'b1, 12'h344, {3'b111, 3'(v), 2'b11});
      apb(1'b0, 12'h344, 8'h00);
      chk("ref_rd", rd, {27'h0, 3'(v), 2'b00});
      exp_src = v[2] ? REF_REGULATOR : (v[1] ? REF_SUPPLY : REF_EXTERNAL_PIN);
      chk("src", 32'(ref_source), 32'(exp_src));
      chk("sen", 32'(sensor_power_on), 32'(v[0]));
      chk("hiz", 32'(sensor_output_en_n), 32'(!v[0]));
    end
    pstrb <= 4'h0;
    apb(1'b1, 12'h344, 8'h00);
    pstrb <= 4'h1;
    chk("strb", 32'(sensor_power_on), 32'h1);
    apb(1'b0, 12'h344, 8'h00); chk("strb_rd", rd, 32'h1c);
    apb(1'b0, 12'h000, 8'h00); chk("unmap", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, 12'h31c, 8'h41); apb(1'b0, 12'h31c, 8'h00);
    chk("reg_rd", rd, 32'h41);
    chk("byp", {regulator_bypass, regulator_on, mem_power_ctrl_en}, 32'h5);
    apb(1'b1, 12'h31c, 8'h00);
    pulse_wait(0, 1'b1);
    chk("stop_on", {regulator_on, reset_sources_live}, 32'h3);
    pulse_wait(1, 1'b0);
    chk("wake", 32'(in_stop), 32'h0);
    apb(1'b1, 12'h31c, 8'h80);
    pulse_wait(0, 1'b1);
    chk("stop_off", {regulator_on, reset_sources_live}, 32'h0);
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("no_wake", 32'(in_stop), 32'h1);
    pulse_wait(2, 1'b0);
    chk("pin_exit", {regulator_on, reset_sources_live}, 32'h3);
    apb(1'b1, 12'h344, 8'h1c);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h344, 8'h00); chk("ref_rst2", rd, 32'h0);
    chk("sen_rst", {sensor_power_on, sensor_output_en_n}, 32'h1);
    summarize();
  end
endmodule // tb
